/* include/acc_pkg.sv */
// Purpose: shared constants for the converter clock and control block
// Assumes: 8-bit register port, 40 MHz bus clock
// Notes:   offsets, field positions and timing counts live here
package acc_pkg;
	// Register map
	localparam logic [7:0] CLK_CFG_ADDR  = 8'h3f; // Clock configuration
	localparam logic [7:0] STATUS_ADDR   = 8'h3e; // Control and status
	localparam logic [7:0] RESULT_ADDR   = 8'h3d; // Result, low byte
	localparam logic [7:0] RESULT_H_ADDR = 8'h3c; // Result, high bits
	localparam logic [7:0] CLK_CFG_RESET = 8'h00; // All fields clear
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	// Clock configuration fields
	localparam int LOW_POWER_BIT   = 7;
	localparam int DIV_HI_BIT      = 6;
	localparam int DIV_LO_BIT      = 5;
	localparam int IN_CLK_SEL_BIT  = 4;
	localparam int FMT_HI_BIT      = 3;
	localparam int FMT_LO_BIT      = 2;
	localparam int LONG_SMP_BIT    = 1;
	localparam int ASYNC_CLK_BIT   = 0;
	// Status fields
	localparam int DONE_BIT        = 7;
	localparam int IRQ_EN_BIT      = 6;
	localparam int START_BIT       = 5;
	localparam int CHAN_LO_BIT     = 0;
	localparam int CHAN_W          = 5;
	// Result formats: only right-justified ones survive
	localparam logic [1:0] FMT_8BIT  = 2'h0;
	localparam logic [1:0] FMT_10BIT = 2'h1;
	// Conversion lengths in converter clocks
	localparam int CONV_SHORT   = 21; // Bus clock, short sample
	localparam int CONV_LONG    = 44; // Async clock, long sample
	localparam int SAMPLE_EXTRA = 20; // Long sample adds this
	localparam int ASYNC_EXTRA  = 3;  // Async start-up overhead
	localparam int CNT_W        = 6;
	localparam int DIV_W        = 3;
endpackage

/* rtl/acc_clock_divider.sv */
// Purpose: makes the converter clock tick from the chosen source
// Assumes: alternate and async ticks are synchronised one-cycle pulses
// Notes:   divide by 1, 2, 4 or 8
`timescale 1ns/1ps
module acc_clock_divider (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clkEn,
	input  wire logic       altTick,
	input  wire logic       asyncTick,
	input  wire logic       useAlt,
	input  wire logic       useAsync,
	input  wire logic [1:0] divideSel,
	output logic            convTick
);
	import acc_pkg::*;

	logic [DIV_W-1:0] count;      // Prescale counter
	logic [DIV_W-1:0] next_count;
	logic             srcTick;    // Selected source tick
	logic [DIV_W-1:0] limit;      // Terminal count

	// Source selection and terminal count
	always_comb begin
		if (useAsync)
			srcTick = asyncTick;
		else if (useAlt)
			srcTick = altTick;
		else
			srcTick = 1'b1;
		limit = DIV_W'((1 << divideSel) - 1); // Power-of-two divide
		next_count = count;
		convTick = 1'b0;
		if (srcTick) begin
			if (count >= limit) begin
				next_count = '0;
				convTick = 1'b1;
			end else begin
				next_count = count + DIV_W'(1);
			end
		end
	end

	// Counter register
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			count <= '0;
		else if (clkEn)
			count <= next_count;
	end
endmodule // acc_clock_divider

/* rtl/acc_conv_seq.sv */
// Purpose: sequences one successive-approximation conversion
// Assumes: convTick marks one converter clock
// Notes:   compare result comes from the analog comparator
`timescale 1ns/1ps
module acc_conv_seq (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clkEn,
	input  wire logic       convTick,
	input  wire logic       start,
	input  wire logic [5:0] convLength,
	input  wire logic       cmpHigh,
	output logic            sampling,
	output logic [9:0]      trial,
	output logic            donePulse,
	output logic [9:0]      result
);
	import acc_pkg::*;

	typedef enum logic [1:0] {IDLE, RUN} acc_seq_t;
	acc_seq_t         state;      // Sequencer state
	acc_seq_t         next_state;
	logic [CNT_W-1:0] count;      // Converter clocks used
	logic [CNT_W-1:0] next_count;
	logic [9:0]       next_trial;
	logic [9:0]       next_result;
	logic [3:0]       bitIdx;     // Bit under test
	logic [3:0]       next_bitIdx;
	logic [CNT_W-1:0] bitStart;   // Clock where bit trials begin

	// Next-state logic; trials fill the last ten clocks
	always_comb begin
		next_state = state;
		next_count = count;
		next_trial = trial;
		next_result = result;
		next_bitIdx = bitIdx;
		donePulse = 1'b0;
		bitStart = convLength - CNT_W'(10);
		unique case (state)
			IDLE: begin
				if (start) begin
					next_state = RUN;
					next_count = '0;
					next_trial = 10'h200;
					next_bitIdx = 4'h9;
				end
			end
			RUN: begin
				if (convTick) begin
					next_count = count + CNT_W'(1);
					if (count >= bitStart) begin
						if (!cmpHigh)
							next_trial[bitIdx] = 1'b0;
						if (bitIdx != 4'h0) begin
							next_trial[bitIdx-4'h1] = 1'b1;
							next_bitIdx = bitIdx - 4'h1;
						end
					end
					if (count == convLength - CNT_W'(1)) begin
						next_state = IDLE;
						next_result = next_trial;
						donePulse = 1'b1;
					end
				end
			end
		endcase
	end

	assign sampling = (state == RUN) && (count < bitStart);

	// State registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= IDLE;
			count <= '0;
			trial <= '0;
			result <= '0;
			bitIdx <= '0;
		end else if (clkEn) begin
			state <= next_state;
			count <= next_count;
			trial <= next_trial;
			result <= next_result;
			bitIdx <= next_bitIdx;
		end
	end
endmodule // acc_conv_seq

/* rtl/acc_top.sv */
// Purpose: converter clock configuration, status and control
// Assumes: register port on clk; pins and async tick are external
// Notes:   conversion continues in stop when the async clock is on
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

module acc_top (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clkEn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic      [7:0] rdData,
	input  wire logic       altClkPin,
	input  wire logic       asyncClkPin,
	input  wire logic       stopMode,
	input  wire logic       cmpHighPin,
	output logic            lowPower,
	output logic            sampling,
	output logic      [9:0] trialCode,
	output logic      [4:0] channel,
	output logic            converting
);
	import acc_pkg::*;

	logic [7:0] clkCfg;        // Clock configuration register
	logic [7:0] next_clkCfg;
	logic       doneFlag;      // Conversion complete
	logic       next_doneFlag;
	logic       irqEnable;     // Kept for software, no effect on done
	logic       next_irqEnable;
	logic [4:0] next_channel;
	logic [7:0] next_rdData;
	logic       startReq;      // Start pulse to the sequencer
	logic [2:0] altSync;       // Sync plus edge stage
	logic [2:0] asyncSync;
	logic       altTick;
	logic       asyncTick;
	logic       convTick;
	logic       tickGated;     // Tick after stop gating
	logic       doneP;
	logic [9:0] result;
	logic [5:0] convLength;
	logic       busy;          // Status view of a conversion in flight
	logic       convActive;    // Set by start, cleared by done
	logic       next_convActive;

	// Pin synchronisers; edge detect reads only stage two onward
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			altSync <= '0;
			asyncSync <= '0;
		end else if (clkEn) begin
			altSync <= {altSync[1:0], altClkPin};
			asyncSync <= {asyncSync[1:0], asyncClkPin};
		end
	end
	assign altTick = altSync[1] & ~altSync[2];
	assign asyncTick = asyncSync[1] & ~asyncSync[2];

	// Length: short base, plus long sample, plus async overhead
	always_comb begin
		convLength = 6'(CONV_SHORT);
		if (clkCfg[LONG_SMP_BIT])
			convLength = convLength + 6'(SAMPLE_EXTRA);
		if (clkCfg[ASYNC_CLK_BIT])
			convLength = convLength + 6'(ASYNC_EXTRA);
	end

	// Stop freezes the bus-clocked path unless async is on
	assign tickGated = convTick & (~stopMode | clkCfg[ASYNC_CLK_BIT]);

	acc_clock_divider u_div (
		.clk      (clk),
		.reset    (reset),
		.clkEn    (clkEn),
		.altTick  (altTick),
		.asyncTick(asyncTick),
		.useAlt   (clkCfg[IN_CLK_SEL_BIT]),
		.useAsync (clkCfg[ASYNC_CLK_BIT]),
		.divideSel({clkCfg[DIV_HI_BIT], clkCfg[DIV_LO_BIT]}),
		.convTick (convTick)
	);

	// Comparator answers the registered trial code within one bus
	// cycle, so it is same-clock logic; a two-stage synchroniser would
	// hand the sequencer a verdict two trials old at divide-by-one
	acc_conv_seq u_seq (
		.clk       (clk),
		.reset     (reset),
		.clkEn     (clkEn),
		.convTick  (tickGated),
		.start     (startReq),
		.convLength(convLength),
		.cmpHigh   (cmpHighPin),
		.sampling  (sampling),
		.trial     (trialCode),
		.donePulse (doneP),
		.result    (result)
	);

	assign busy = convActive;
	assign lowPower = clkCfg[LOW_POWER_BIT];

	// Register writes and flag update
	always_comb begin
		next_clkCfg = clkCfg;
		next_doneFlag = doneFlag;
		next_irqEnable = irqEnable;
		next_channel = channel;
		startReq = 1'b0;
		next_convActive = convActive;
		if (wrStb && addr == CLK_CFG_ADDR) begin
			next_clkCfg = wrData;
			if (wrData[FMT_HI_BIT])
				next_clkCfg[FMT_HI_BIT] = 1'b0;
		end
		if (wrStb && addr == STATUS_ADDR) begin
			// Writing status clears done; start bit set in the data starts a conversion
			next_irqEnable = wrData[IRQ_EN_BIT];
			next_channel = wrData[CHAN_LO_BIT +: CHAN_W];
			next_doneFlag = 1'b0;
			startReq = wrData[START_BIT];
		end
		if (rdStb && addr == RESULT_ADDR)
			next_doneFlag = 1'b0;
		// Set wins over clear, independent of irq enable
		if (doneP)
			next_doneFlag = 1'b1;
		// Busy follows the sequencer: start raises it, done drops it
		if (startReq)
			next_convActive = 1'b1;
		if (doneP)
			next_convActive = 1'b0;
	end

	// Read mux; done bit is read-only
	always_comb begin
		next_rdData = 8'h00;
		if (rdStb) begin
			unique case (addr)
				CLK_CFG_ADDR: next_rdData = clkCfg;
				STATUS_ADDR:  next_rdData = {doneFlag, irqEnable,
					busy, channel};
				RESULT_ADDR: begin
					if (clkCfg[FMT_LO_BIT +: 2] == FMT_10BIT)
						next_rdData = result[7:0];
					else
						next_rdData = result[9:2];
				end
				RESULT_H_ADDR: next_rdData = {6'h00, result[9:8]};
				default:      next_rdData = 8'h00;
			endcase
		end
	end

	// Register state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clkCfg <= CLK_CFG_RESET;
			doneFlag <= 1'b0;
			irqEnable <= 1'b0;
			channel <= '0;
			rdData <= 8'h00;
			convActive <= 1'b0;
		end else if (clkEn) begin
			clkCfg <= next_clkCfg;
			doneFlag <= next_doneFlag;
			irqEnable <= next_irqEnable;
			channel <= next_channel;
			rdData <= next_rdData;
			convActive <= next_convActive;
		end
	end
	assign converting = convActive;

	// Checks
	property p_done_sets;
		@(posedge clk) disable iff (reset)
		(clkEn && doneP) |=> doneFlag;
	endproperty
	a_done_sets: assert property (p_done_sets)
		else $error("done flag not set after conversion");

	property p_lowpower;
		@(posedge clk) disable iff (reset)
		(clkEn && wrStb && addr == CLK_CFG_ADDR)
		|=> lowPower == |($past(wrData) & 8'(1 << LOW_POWER_BIT));
	endproperty
	a_lowpower: assert property (p_lowpower)
		else $error("low power output mismatch");

	property p_no_left;
		@(posedge clk) disable iff (reset)
		!clkCfg[FMT_HI_BIT];
	endproperty
	a_no_left: assert property (p_no_left)
		else $error("left justified format stored");

	property p_len;
		@(posedge clk) disable iff (reset)
		convLength >= 6'(CONV_SHORT) && convLength <= 6'(CONV_LONG);
	endproperty
	a_len: assert property (p_len)
		else $error("conversion length out of range");

	property p_cfg_write;
		@(posedge clk) disable iff (reset)
		(clkEn && wrStb && addr == CLK_CFG_ADDR && !wrData[FMT_HI_BIT])
		|=> clkCfg == $past(wrData);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("clock register write lost");

	property p_stop;
		@(posedge clk) disable iff (reset)
		(stopMode && !clkCfg[ASYNC_CLK_BIT]) |-> !tickGated;
	endproperty
	a_stop: assert property (p_stop)
		else $error("tick in stop without async clock");

	property p_done_clear_wr;
		@(posedge clk) disable iff (reset)
		(clkEn && wrStb && addr == STATUS_ADDR && !doneP) |=> !doneFlag;
	endproperty
	a_done_clear_wr: assert property (p_done_clear_wr)
		else $error("done flag not cleared by status write");

	property p_done_clear_rd;
		@(posedge clk) disable iff (reset)
		(clkEn && rdStb && addr == RESULT_ADDR && !doneP) |=> !doneFlag;
	endproperty
	a_done_clear_rd: assert property (p_done_clear_rd)
		else $error("done flag not cleared by result read");

	property p_done_hold;
		@(posedge clk) disable iff (reset)
		(clkEn && !doneP && !(wrStb && addr == STATUS_ADDR)
			&& !(rdStb && addr == RESULT_ADDR))
		|=> doneFlag == $past(doneFlag);
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("done flag changed without cause");

	property p_long_len;
		@(posedge clk) disable iff (reset)
		clkCfg[LONG_SMP_BIT]
		|-> convLength >= 6'(CONV_SHORT + SAMPLE_EXTRA);
	endproperty
	a_long_len: assert property (p_long_len)
		else $error("long sample did not lengthen conversion");

	property p_start_samples;
		@(posedge clk) disable iff (reset)
		(clkEn && startReq && !convActive) |=> sampling;
	endproperty
	a_start_samples: assert property (p_start_samples)
		else $error("conversion did not open with sampling");

	property p_async_run;
		@(posedge clk) disable iff (reset)
		(clkEn && clkCfg[ASYNC_CLK_BIT] && convTick) |-> tickGated;
	endproperty
	a_async_run: assert property (p_async_run)
		else $error("async tick lost");

	property p_short_len;
		@(posedge clk) disable iff (reset)
		(!clkCfg[ASYNC_CLK_BIT] && !clkCfg[LONG_SMP_BIT])
		|-> convLength == 6'(CONV_SHORT);
	endproperty
	a_short_len: assert property (p_short_len)
		else $error("short conversion length wrong");

	property p_full_len;
		@(posedge clk) disable iff (reset)
		(clkCfg[ASYNC_CLK_BIT] && clkCfg[LONG_SMP_BIT])
		|-> convLength == 6'(CONV_LONG);
	endproperty
	a_full_len: assert property (p_full_len)
		else $error("longest conversion length wrong");

	property p_busy_end;
		@(posedge clk) disable iff (reset)
		(clkEn && doneP) |=> !converting;
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("still converting after done");

	property p_rd_cfg;
		@(posedge clk) disable iff (reset)
		(clkEn && rdStb && addr == CLK_CFG_ADDR) |=> rdData == $past(clkCfg);
	endproperty
	a_rd_cfg: assert property (p_rd_cfg)
		else $error("clock register read wrong");

	property p_rd_idle;
		@(posedge clk) disable iff (reset)
		(clkEn && !rdStb) |=> rdData == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without a read");

	property p_alt_pulse;
		@(posedge clk) disable iff (reset)
		(clkEn && altTick) |=> !altTick;
	endproperty
	a_alt_pulse: assert property (p_alt_pulse)
		else $error("alternate tick longer than one cycle");
endmodule // acc_top

/* testbench/acc_analog_model.sv */
// Purpose: analog input pins seen by the converter comparator
// Assumes: each channel pin holds one fixed level during a run
// Notes:   pins are set as inputs, so no digital drive disturbs them
`timescale 1ns/1ps
module acc_analog_model (
	input  wire logic [9:0] trialCode,
	input  wire logic [4:0] channel,
	output logic            cmpHighPin
);
	// Level of the selected pin, a ramp over the channels
	logic [9:0] level;
	// Pin held as input, so only the analog level reaches it
	assign level = {channel, 5'h00} + 10'h015;
	// Comparator says high while the input is at or above the trial
	assign cmpHighPin = (level >= trialCode);
endmodule // acc_analog_model

/* testbench/adc_clock_config_bench.sv */
// Purpose: self-checking bench for the converter clock block
// Assumes: register port on clk, pins driven by the bench
// Notes:   conversion lengths measured on the converting level
`timescale 1ns/1ps
module adc_clock_config_bench;
	import acc_pkg::*;
	logic       clk, reset, clkEn, wrStb, rdStb, stopMode;
	logic       altClkPin, asyncClkPin, altRun, asyncRun;
	logic [7:0] addr, wrData, rdData, d, lo;
	logic       lowPower, sampling, converting, cmpHighPin;
	logic [9:0] trialCode;
	logic [4:0] channel;
	int         err_count, num_checks, n, nShort, i;
	// Rows: value written, value read back (bit 3 cannot be set)
	logic [7:0] cfgIn [4] = '{8'hff, 8'h80, 8'h55, 8'h2a};
	logic [7:0] cfgExp [4] = '{8'hf7, 8'h80, 8'h55, 8'h22};

	acc_top dut (.clk, .reset, .clkEn, .addr, .wrData, .wrStb, .rdStb,
		.rdData, .altClkPin, .asyncClkPin, .stopMode, .cmpHighPin,
		.lowPower, .sampling, .trialCode, .channel, .converting);
	acc_analog_model pins (.trialCode, .channel, .cmpHighPin);

	// Bus clock and two unrelated pin clocks, the latter gated
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial forever #35 altClkPin = altRun & ~altClkPin;
	initial forever #55 asyncClkPin = asyncRun & ~asyncClkPin;

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1;
		@(posedge clk);
		wrStb <= 0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rdStb <= 1;
		@(posedge clk);
		rdStb <= 0;
		#1 d = rdData;
	endtask
	// Start on a channel, count cycles until converting drops
	task automatic conv(logic [7:0] cfg, logic [4:0] ch);
		logic [9:0] e; // Level the pin model holds
		e = {ch, 5'h00} + 10'h015;
		wr(CLK_CFG_ADDR, cfg);
		wr(STATUS_ADDR, {3'b001, ch});
		n = 0;
		#1;
		while (converting !== 1'b0 && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		check("conv_end", n < 3000, 1'b1);
		rd(STATUS_ADDR);
		check("done", d[DONE_BIT], 1'b1);
		rd(RESULT_ADDR);
		lo = d;
		rd(RESULT_H_ADDR);
		check("result_hi", d, {6'h00, e[9:8]});
		if (cfg[FMT_LO_BIT])
			check("result_lo", lo, e[7:0]);
		else
			check("result_8b", lo, e[9:2]);
	endtask
	task automatic summarize;
		$display("Checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#2000000;
		err_count++;
		summarize;
	end

	initial begin
		{reset, clkEn, wrStb, rdStb, stopMode} = 5'b11000;
		{altRun, asyncRun, altClkPin, asyncClkPin} = 4'h0;
		addr = 8'h00;
		wrData = 8'h00;
		err_count = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		reset <= 0;
		rd(CLK_CFG_ADDR);
		check("cfg_reset", d, CLK_CFG_RESET);
		rd(8'h10);
		check("unmapped", d, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(CLK_CFG_ADDR, cfgIn[i]);
			rd(CLK_CFG_ADDR);
			check("cfg", d, cfgExp[i]);
			check("lowPower", lowPower, cfgExp[i][7]);
		end
		// Writing a one to the done bit does not set it
		wr(STATUS_ADDR, 8'h80);
		rd(STATUS_ADDR);
		check("done_ro", d[DONE_BIT], 1'b0);
		conv(8'h04, 5'h03);
		nShort = n;
		check("short_len", 16'(n), 16'(CONV_SHORT));
		conv(8'h06, 5'h11);
		check("long_extra", 16'(n - nShort), 16'd20);
		conv(8'h24, 5'h07);
		check("div2", n >= 2*nShort-2 && n <= 2*nShort+2, 1'b1);
		// Eight-bit format returns the top bits in the low byte
		conv(8'h00, 5'h15);
		check("fmt8_len", 16'(n), 16'(CONV_SHORT));
		// Alternate pin ticks every 2.8 bus cycles
		altRun = 1;
		conv(8'h14, 5'h1f);
		check("alt_len", 16'(n / nShort), 16'd2);
		altRun = 0;
		// Stop without the async clock freezes a bus-clocked conversion
		wr(CLK_CFG_ADDR, 8'h04);
		@(posedge clk) stopMode <= 1;
		wr(STATUS_ADDR, 8'h23);
		repeat (3*CONV_SHORT) @(posedge clk);
		#1 check("stop_hold", converting, 1'b1);
		@(posedge clk) stopMode <= 0;
		repeat (CONV_SHORT + 2) @(posedge clk);
		#1 check("stop_resume", converting, 1'b0);
		// Async clock keeps converting with the chip stopped
		asyncRun = 1;
		@(posedge clk) stopMode <= 1;
		conv(8'h07, 5'h0a);
		check("async_stop", 16'(n / CONV_LONG), 16'd4);
		@(posedge clk) stopMode <= 0;
		asyncRun = 0;
		// Reset in mid-run clears the register again
		wr(CLK_CFG_ADDR, 8'h55);
		@(posedge clk) reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		rd(CLK_CFG_ADDR);
		check("cfg_rerun", d, CLK_CFG_RESET);
		// Clock enable low freezes every register
		@(posedge clk) clkEn <= 0;
		wr(CLK_CFG_ADDR, 8'h81);
		@(posedge clk) clkEn <= 1;
		rd(CLK_CFG_ADDR);
		check("cfg_frozen", d, CLK_CFG_RESET);
		check("lp_frozen", lowPower, 1'b0);
		summarize;
	end
endmodule // adc_clock_config_bench
